// ==== design/cbmrd_clkgen.sv ====
`timescale 1ns/1ps
`default_nettype none
// Free-running non-overlapping two-phase generator.
module cbmrd_clkgen (
   input wire logic clk_i,
   input wire logic reset_i,
   cbmrd_phase_if.gen ph
);
   localparam int unsigned CW = 8;
   localparam logic [CW-1:0] GAP = CW'(cbmrd_pkg::GAP_CYC);
   localparam logic [CW-1:0] P2N = CW'(cbmrd_pkg::PH2_CYC);
   localparam logic [CW-1:0] P2W = CW'(cbmrd_pkg::PH2W_CYC);
   localparam logic [CW-1:0] CYC = CW'(cbmrd_pkg::CYCLE_CYC);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] p2len_q;
   logic [CW-1:0] end_c;
   logic p1_q;
   logic p2_q;
   logic rise_q;

   // Phase two length is latched at its start so a stretch cannot cause overlap.
   always_comb begin
      end_c = CYC + p2len_q - P2N;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= '0;
         p2len_q <= CW'(cbmrd_pkg::PH2_CYC);
      end else if (cnt_q >= end_c - CW'(1)) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(1);
         if (cnt_q == (CYC - P2N - GAP - CW'(1))) begin
            p2len_q <= ph.stretch ? P2W : P2N; // see RULE15
         end
      end
   end

   // Phase one occupies the front, a gap, phase two, then a gap: see RULE16
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         p1_q <= (cnt_q < (CYC - P2N - GAP - GAP - CW'(1))) && (cnt_q != end_c - CW'(1));
         rise_q <= (cnt_q == end_c - CW'(1));
         p2_q <= (cnt_q >= (CYC - P2N - GAP)) && (cnt_q < end_c - GAP);
      end
   end

   assign ph.ph1 = p1_q;
   assign ph.ph2 = p2_q;
   assign ph.ph1_rise = rise_q;
endmodule // cbmrd_clkgen
`default_nettype wire

// ==== design/cbmrd_phase_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Phase timing shared between the clock generator and the sequencer.
interface cbmrd_phase_if;
   logic ph1;
   logic ph2;
   logic ph1_rise;
   logic stretch;
   modport gen (output ph1, output ph2, output ph1_rise, input stretch);
   modport use_ (input ph1, input ph2, input ph1_rise, output stretch);
endinterface
`default_nettype wire

// ==== design/cbmrd_pkg.sv ====
// Functional notes
// RULE1 - Refresh every row within each 2 ms.
// RULE2 - Timer fires: raise renew request, stall processor.
// RULE3 - Processor finishes instruction, then releases bus.
// RULE4 - Row counter steps each phase-one after halt.
// RULE5 - At 64 rows clear request, release stall.
// RULE6 - Refresh proceeds even if processor hangs.
// RULE7 - Data buffers toward processor when read high.
// RULE8 - Addresses 0000-0FFF assert RAM select and enable.
// RULE9 - RAM enable also asserted during refresh.
// RULE10 - Write strobe lags RAM enable by 200 ns.
// RULE11 - RAM read buffers enabled only on reads.
// RULE12 - FC00-FFFF select one of four PROMs.
// RULE13 - Spare port selects only for F040-F043.
// RULE14 - RAM is 4K blocks of eight 1-bit devices.
// RULE15 - Phase two stretched to 1.0 us on writes.
// RULE16 - Free non-overlapping phases, 1.34 us cycle. The code runs 33 cycles of 40 ns, which is 1.32 us.
// RULE17 - Tick counter divides refresh pulses, selectable rate.
// RULE18 - Address F044 resets the tick counter.
// RULE19 - System reset clears the tick counter.
// RULE20 - Tick drives port A interrupt input.
// RULE21 - Timer event during refresh is ignored.
package cbmrd_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned CLK_NS = 40;
   localparam int unsigned REFRESH_US = 2000;
   localparam int unsigned REFRESH_CYC = REFRESH_US * (CLK_HZ / 1000000);
   localparam int unsigned CYCLE_NS = 1340;
   localparam int unsigned CYCLE_CYC = CYCLE_NS / CLK_NS;
   localparam int unsigned PH2_NS = 840;
   localparam int unsigned PH2_CYC = PH2_NS / CLK_NS;
   localparam int unsigned PH2W_NS = 1000;
   localparam int unsigned PH2W_CYC = (PH2W_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned GAP_NS = 80;
   localparam int unsigned GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WE_DLY_NS = 200;
   localparam int unsigned WE_DLY_CYC = (WE_DLY_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned ROWS = 64;
   localparam logic [15:0] RAM_LAST = 16'h0FFF;
   localparam logic [15:0] PROM_BASE = 16'hFC00;
   localparam logic [15:0] PORT_BASE = 16'hF040;
   localparam logic [15:0] PORT_LAST = 16'hF043;
   localparam logic [15:0] TICK_CLR = 16'hF044;
   localparam int unsigned PROM_SEL_LSB = 8;
   localparam int unsigned TICK_W = 8;
   localparam int unsigned TICK_SEL_BASE = 4;
   // Cycles the sequencer waits for a bus release before taking the bus anyway.
   localparam int unsigned HOLD_LIMIT = 1000;
   typedef enum logic [1:0] {
      CBMRD_IDLE = 2'b00,
      CBMRD_WAIT = 2'b01,
      CBMRD_ROWS = 2'b10
   } cbmrd_state_t;
endpackage

// ==== design/cbmrd_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Memory control: refresh sequencer, address decode, data steering, tick counter.
module cbmrd_top #(
   parameter int unsigned REFRESH_COUNT = cbmrd_pkg::REFRESH_CYC,
   parameter int unsigned ROW_COUNT = cbmrd_pkg::ROWS
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [15:0] addr_i,
   input wire logic rnw_i,
   input wire logic vma_i,
   input wire logic bus_released_i,
   input wire logic [1:0] tick_sel_i,
   output logic ph1_o,
   output logic ph2_o,
   output logic stall_o,
   output logic renew_o,
   output logic row_drive_o,
   output logic [5:0] row_addr_o,
   output logic cpu_addr_en_o,
   output logic buf_to_cpu_o,
   output logic ram_sel_o,
   output logic ram_en_o,
   output logic ram_we_o,
   output logic ram_rd_oe_o,
   output logic [3:0] prom_sel_o,
   output logic [7:0] prom_word_o,
   output logic port_sel_o,
   output logic [1:0] port_reg_o,
   output logic port_a_irq_input_o
);
   localparam int unsigned RW = $clog2(ROW_COUNT + 1);
   localparam int unsigned TW = $clog2(REFRESH_COUNT + 1);
   localparam int unsigned HW = $clog2(cbmrd_pkg::HOLD_LIMIT + 1);
   localparam int unsigned WE_W = 4;

   if (ROW_COUNT < 2 || ROW_COUNT > 64) begin : g_bad_rows
      $error("ROW_COUNT out of range");
   end
   if (REFRESH_COUNT < 2) begin : g_bad_refresh
      $error("REFRESH_COUNT too small");
   end

   cbmrd_phase_if ph ();

   cbmrd_clkgen u_clkgen (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ph(ph.gen)
   );

   // Pin inputs pass two flip-flops before use.
   logic [15:0] addr_m_q, addr_q;
   logic rnw_m_q, rnw_q, vma_m_q, vma_q, rel_m_q, rel_q;
   logic [1:0] sel_m_q, sel_q;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         addr_m_q <= '0;
         addr_q <= '0;
         rnw_m_q <= 1'b1;
         rnw_q <= 1'b1;
         vma_m_q <= 1'b0;
         vma_q <= 1'b0;
         rel_m_q <= 1'b0;
         rel_q <= 1'b0;
         sel_m_q <= '0;
         sel_q <= '0;
      end else begin
         sel_m_q <= tick_sel_i;
         sel_q <= sel_m_q;
         addr_m_q <= addr_i;
         addr_q <= addr_m_q;
         rnw_m_q <= rnw_i;
         rnw_q <= rnw_m_q;
         vma_m_q <= vma_i;
         vma_q <= vma_m_q;
         rel_m_q <= bus_released_i;
         rel_q <= rel_m_q;
      end
   end

   // Free-running refresh timer.
   logic [TW-1:0] tmr_q;
   logic fire_q;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tmr_q <= '0;
         fire_q <= 1'b0;
      end else if (tmr_q == TW'(REFRESH_COUNT - 1)) begin
         tmr_q <= '0;
         fire_q <= 1'b1; // see RULE1
      end else begin
         tmr_q <= tmr_q + TW'(1);
         fire_q <= 1'b0;
      end
   end

   // Refresh sequencer.
   cbmrd_pkg::cbmrd_state_t st_q;
   logic [RW-1:0] row_q;
   logic [HW-1:0] hold_q;
   logic done_q;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= cbmrd_pkg::CBMRD_IDLE;
         row_q <= '0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (st_q)
            cbmrd_pkg::CBMRD_IDLE: begin
               if (fire_q) begin
                  st_q <= cbmrd_pkg::CBMRD_WAIT; // see RULE2
               end
            end
            cbmrd_pkg::CBMRD_WAIT: begin
               // A processor that never lets go of the bus is overridden after a bounded wait.
               if ((rel_q || hold_q == HW'(cbmrd_pkg::HOLD_LIMIT)) && ph.ph1_rise) begin
                  st_q <= cbmrd_pkg::CBMRD_ROWS; // see RULE3 RULE6
               end
            end
            cbmrd_pkg::CBMRD_ROWS: begin
               if (ph.ph1_rise) begin
                  if (row_q == RW'(ROW_COUNT - 1)) begin
                     row_q <= '0; // see RULE5
                     st_q <= cbmrd_pkg::CBMRD_IDLE;
                     done_q <= 1'b1;
                  end else begin
                     row_q <= row_q + RW'(1); // see RULE4
                  end
               end
            end
            default: st_q <= cbmrd_pkg::CBMRD_IDLE;
         endcase
         // A timer event outside IDLE is simply dropped: see RULE21
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         hold_q <= '0;
      end else if (st_q != cbmrd_pkg::CBMRD_WAIT) begin
         hold_q <= '0;
      end else if (hold_q != HW'(cbmrd_pkg::HOLD_LIMIT)) begin
         hold_q <= hold_q + HW'(1); // see RULE6
      end
   end

   logic renew_c;
   logic rowdrv_c;
   assign renew_c = (st_q != cbmrd_pkg::CBMRD_IDLE);
   assign rowdrv_c = (st_q == cbmrd_pkg::CBMRD_ROWS);

   // Address decode and RAM write spacing.
   logic cpu_c;
   logic ram_hit_c;
   logic [WE_W-1:0] we_cnt_q;
   assign cpu_c = vma_q && !renew_c;
   assign ram_hit_c = cpu_c && (addr_q <= cbmrd_pkg::RAM_LAST); // see RULE8 RULE14

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         we_cnt_q <= '0;
      end else if (ram_hit_c && !rnw_q) begin
         if (we_cnt_q != WE_W'(cbmrd_pkg::WE_DLY_CYC)) begin
            we_cnt_q <= we_cnt_q + WE_W'(1); // see RULE10
         end
      end else begin
         we_cnt_q <= '0;
      end
   end

   // Tick counter divides completed refreshes.
   logic [cbmrd_pkg::TICK_W-1:0] tick_q;
   logic tick_clr_c;
   assign tick_clr_c = vma_q && (addr_q == cbmrd_pkg::TICK_CLR);
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tick_q <= '0; // see RULE19
      end else if (tick_clr_c) begin
         tick_q <= '0; // see RULE18
      end else if (done_q) begin
         tick_q <= tick_q + cbmrd_pkg::TICK_W'(1); // see RULE17
      end
   end

   // Registered outputs.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         renew_o <= 1'b0;
         stall_o <= 1'b0;
         row_drive_o <= 1'b0;
         row_addr_o <= '0;
         cpu_addr_en_o <= 1'b1;
         buf_to_cpu_o <= 1'b1;
         ram_sel_o <= 1'b0;
         ram_en_o <= 1'b0;
         ram_we_o <= 1'b0;
         ram_rd_oe_o <= 1'b0;
         prom_sel_o <= '0;
         prom_word_o <= '0;
         port_sel_o <= 1'b0;
         port_reg_o <= '0;
         port_a_irq_input_o <= 1'b0;
      end else begin
         renew_o <= renew_c; // see RULE2
         stall_o <= renew_c;
         row_drive_o <= rowdrv_c;
         row_addr_o <= 6'(row_q); // see RULE4
         cpu_addr_en_o <= !((renew_c && rel_q) || rowdrv_c); // see RULE3 RULE6
         buf_to_cpu_o <= rnw_q; // see RULE7
         ram_sel_o <= ram_hit_c; // see RULE8
         ram_en_o <= ram_hit_c || renew_c; // see RULE9
         ram_we_o <= ram_hit_c && !rnw_q
                     && (we_cnt_q == WE_W'(cbmrd_pkg::WE_DLY_CYC)); // see RULE10
         ram_rd_oe_o <= ram_hit_c && rnw_q; // see RULE11
         prom_sel_o <= '0;
         if (cpu_c && addr_q >= cbmrd_pkg::PROM_BASE) begin
            prom_sel_o[addr_q[cbmrd_pkg::PROM_SEL_LSB +: 2]] <= 1'b1; // see RULE12
         end
         prom_word_o <= addr_q[7:0];
         port_sel_o <= cpu_c && (addr_q >= cbmrd_pkg::PORT_BASE)
                       && (addr_q <= cbmrd_pkg::PORT_LAST); // see RULE13
         port_reg_o <= addr_q[1:0];
         port_a_irq_input_o <= tick_q[3'(sel_q) + 3'(cbmrd_pkg::TICK_SEL_BASE)]; // see RULE20
      end
   end

   // Phase two stretches on RAM writes.
   assign ph.stretch = ram_hit_c && !rnw_q; // see RULE15
   assign ph1_o = ph.ph1; // see RULE16
   assign ph2_o = ph.ph2;
endmodule // cbmrd_top
`default_nettype wire

// ==== sim/cbmrd_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbmrd_assertions #(
   parameter int unsigned REFRESH_COUNT = 200
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [15:0] addr_i,
   input wire logic ph1_o,
   input wire logic ph2_o,
   input wire logic stall_o,
   input wire logic renew_o,
   input wire logic row_drive_o,
   input wire logic cpu_addr_en_o,
   input wire logic ram_sel_o,
   input wire logic ram_en_o,
   input wire logic ram_we_o,
   input wire logic ram_rd_oe_o,
   input wire logic [3:0] prom_sel_o,
   input wire logic [7:0] prom_word_o,
   input wire logic port_sel_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   int unsigned gap_q;
   // Cycles since the last refresh, so a missed timer event shows up.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) gap_q <= 0;
      else gap_q <= renew_o ? 0 : gap_q + 1;
   end
   property p_gap; gap_q <= REFRESH_COUNT + 4; endproperty
   a_gap: assert property (p_gap) else $error("refresh overdue");
   property p_ph_sep; !(ph1_o && ph2_o); endproperty
   a_ph_sep: assert property (p_ph_sep) else $error("phases overlap");
   property p_stall; stall_o == renew_o; endproperty
   a_stall: assert property (p_stall) else $error("stall differs from renew");
   property p_ce_ref; renew_o && $past(renew_o) |-> ram_en_o; endproperty
   a_ce_ref: assert property (p_ce_ref) else $error("no enable in refresh");
   property p_we_lag; $rose(ram_we_o) |-> ram_en_o && $past(ram_en_o, 5); endproperty
   a_we_lag: assert property (p_we_lag) else $error("write strobe early");
   property p_rd_wr; ram_we_o |-> !ram_rd_oe_o; endproperty
   a_rd_wr: assert property (p_rd_wr) else $error("read buffer on in write");
   property p_ram_dec; ram_sel_o |-> $past(addr_i, 3) <= 16'h0FFF; endproperty
   a_ram_dec: assert property (p_ram_dec) else $error("ram select outside");
   property p_prom;
      |prom_sel_o |-> $past(addr_i[15:10], 3) == 6'h3F
         && prom_sel_o == (4'h1 << $past(addr_i[9:8], 3)) && prom_word_o == $past(addr_i[7:0], 3);
   endproperty
   a_prom: assert property (p_prom) else $error("prom decode wrong");
   property p_port; port_sel_o |-> $past(addr_i, 3) inside {[16'hF040:16'hF043]}; endproperty
   a_port: assert property (p_port) else $error("port select outside");
   property p_bus; row_drive_o |-> !cpu_addr_en_o && renew_o; endproperty
   a_bus: assert property (p_bus) else $error("rows drive with cpu on bus");
   c_renew: cover property ($rose(renew_o));
   c_we: cover property ($rose(ram_we_o));
   c_port: cover property (port_sel_o);
endmodule // cbmrd_assertions
bind cbmrd_top cbmrd_assertions #(.REFRESH_COUNT(REFRESH_COUNT)) i_chk (.clk_i(clk_i),
   .reset_i(reset_i), .addr_i(addr_i), .ph1_o(ph1_o), .ph2_o(ph2_o), .stall_o(stall_o),
   .renew_o(renew_o), .row_drive_o(row_drive_o), .cpu_addr_en_o(cpu_addr_en_o),
   .ram_sel_o(ram_sel_o), .ram_en_o(ram_en_o), .ram_we_o(ram_we_o), .ram_rd_oe_o(ram_rd_oe_o),
   .prom_sel_o(prom_sel_o), .prom_word_o(prom_word_o), .port_sel_o(port_sel_o));
`default_nettype wire

// ==== sim/cbmrd_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbmrd_cpu_model (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic stall_i,
   input wire logic [3:0] lag_i,
   input wire logic hang_i,
   output logic bus_released_o
);
   logic [3:0] wait_q;
   // The core ends its current instruction, lag_i cycles, before letting go of the bus.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i || !stall_i) begin
         wait_q <= 4'h0;
         bus_released_o <= 1'b0;
      end else if (wait_q == lag_i && !hang_i) begin
         bus_released_o <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule // cbmrd_cpu_model
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [15:0] addr_i = 16'h2000;
   logic rnw_i = 1'b1;
   logic vma_i = 1'b0;
   logic [1:0] tick_sel_i = 2'h0;
   logic [3:0] lag = 4'h0;
   logic hang = 1'b0;
   logic rel, ph1, ph2, stall, renew, rdrv, cpu_en, to_cpu, rsel, ren, rwe, rdoe, psel, irq;
   logic [5:0] row;
   logic [3:0] prom;
   logic [7:0] word;
   logic [1:0] preg;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         summarize();
      end
   end
   cbmrd_top #(.REFRESH_COUNT(2300)) i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .rnw_i(rnw_i), .vma_i(vma_i), .bus_released_i(rel), .tick_sel_i(tick_sel_i), .ph1_o(ph1),
      .ph2_o(ph2), .stall_o(stall), .renew_o(renew), .row_drive_o(rdrv), .row_addr_o(row),
      .cpu_addr_en_o(cpu_en), .buf_to_cpu_o(to_cpu), .ram_sel_o(rsel), .ram_en_o(ren),
      .ram_we_o(rwe), .ram_rd_oe_o(rdoe), .prom_sel_o(prom), .prom_word_o(word),
      .port_sel_o(psel), .port_reg_o(preg), .port_a_irq_input_o(irq));
   cbmrd_cpu_model i_cpu (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall), .lag_i(lag),
      .hang_i(hang), .bus_released_o(rel));
   task chk(string n, logic [15:0] e, logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task go(logic [15:0] a, logic r);
      @(posedge clk_i);
      #5;
      addr_i = a;
      rnw_i = r;
      vma_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #5;
   endtask
   // Period from one phase-one rise to the next, and phase-two high cycles inside it.
   task measure(output int per, output int wid);
      int k;
      k = 0;
      while (ph1 !== 1'b0 && k < 100) begin
         @(posedge clk_i);
         #5;
         k++;
      end
      while (ph1 !== 1'b1 && k < 200) begin
         @(posedge clk_i);
         #5;
         k++;
      end
      per = 0;
      wid = 0;
      while (ph1 === 1'b1 && per < 100) begin
         @(posedge clk_i);
         #5;
         per++;
      end
      while (ph1 !== 1'b1 && per < 100) begin
         if (ph2 === 1'b1) wid++;
         @(posedge clk_i);
         #5;
         per++;
      end
   endtask
   task t_phase;
      int per;
      int wid;
      measure(per, wid);
      chk("ph_period", 16'(cbmrd_pkg::CYCLE_CYC), 16'(per));
      chk("ph2_width", 16'(cbmrd_pkg::PH2_CYC), 16'(wid));
      addr_i = 16'h0100;
      rnw_i = 1'b0;
      vma_i = 1'b1;
      repeat (40) @(posedge clk_i);
      #5;
      measure(per, wid);
      chk("ph_period_wr", 16'(cbmrd_pkg::CYCLE_CYC + cbmrd_pkg::PH2W_CYC - cbmrd_pkg::PH2_CYC),
         16'(per));
      chk("ph2_width_wr", 16'(cbmrd_pkg::PH2W_CYC), 16'(wid));
      addr_i = 16'h2000;
      rnw_i = 1'b1;
      vma_i = 1'b0;
      $display("test phase done");
   endtask
   task t_decode;
      logic [15:0] t [11] = '{16'h0000, 16'h0FFF, 16'h1000, 16'hF03F, 16'hF040, 16'hF043,
         16'hF044, 16'hFBFF, 16'hFC00, 16'hFDA5, 16'hFFFF};
      foreach (t[i]) begin
         go(t[i], 1'b1);
         chk("ram_sel", t[i] <= 16'h0FFF, rsel);
         chk("ram_en", t[i] <= 16'h0FFF, ren);
         chk("rd_oe", t[i] <= 16'h0FFF, rdoe);
         chk("to_cpu", 16'h1, to_cpu);
         chk("prom_sel", t[i] >= 16'hFC00 ? 4'h1 << t[i][9:8] : 4'h0, prom);
         if (t[i] >= 16'hFC00) chk("prom_word", t[i][7:0], word);
         chk("port_sel", t[i] inside {[16'hF040:16'hF043]}, psel);
         chk("port_reg", t[i][1:0], preg);
      end
      go(16'h0800, 1'b0);
      chk("to_cpu_wr", 16'h0, to_cpu);
      chk("we_early", 16'h0, rwe);
      repeat (5) @(posedge clk_i);
      #5;
      chk("we", 16'h1, rwe);
      chk("rd_oe_wr", 16'h0, rdoe);
      go(16'h2000, 1'b1);
      vma_i = 1'b0;
      $display("test decode done");
   endtask
   task t_refresh(logic [3:0] l, logic h);
      int n;
      int k;
      logic [5:0] last;
      logic off;
      lag = l;
      hang = h;
      k = 0;
      while (renew !== 1'b1 && k < 5000) begin
         @(posedge clk_i);
         #5;
         k++;
      end
      chk("stall", 16'h1, stall);
      n = 0;
      k = 0;
      off = 1'b0;
      last = row;
      while (renew === 1'b1 && k < 4000) begin
         @(posedge clk_i);
         #5;
         k++;
         if (cpu_en === 1'b0) off = 1'b1;
         if (row !== last) begin
            chk("row_step", 6'(last + 6'h1), row);
            n++;
            last = row;
         end
      end
      chk("rows", 16'd64, 16'(n));
      chk("row_end", 16'h0, row);
      chk("stall_end", 16'h0, stall);
      chk("cpu_off", 16'h1, off);
      hang = 1'b0;
      $display("test refresh lag %0d hang %0d done", l, h);
   endtask
   task t_tick;
      int k;
      go(16'hF044, 1'b1);
      vma_i = 1'b0;
      for (int r = 1; r <= 16; r++) begin
         k = 0;
         while (renew !== 1'b1 && k < 5000) begin
            @(posedge clk_i);
            #5;
            k++;
         end
         while (renew === 1'b1 && k < 10000) begin
            @(posedge clk_i);
            #5;
            k++;
         end
         if (r >= 15) begin
            repeat (3) @(posedge clk_i);
            #5;
            chk("tick", 16'(r == 16), irq);
         end
      end
      tick_sel_i = 2'h1;
      repeat (4) @(posedge clk_i);
      #5;
      chk("tick_sel", 16'h0, irq);
      tick_sel_i = 2'h0;
      repeat (4) @(posedge clk_i);
      #5;
      chk("tick_back", 16'h1, irq);
      go(16'hF044, 1'b1);
      vma_i = 1'b0;
      chk("tick_clr", 16'h0, irq);
      $display("test tick done");
   endtask
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      chk("irq_reset", 16'h0, irq);
      #5 reset_i = 1'b0;
      t_phase();
      t_refresh(4'h0, 1'b0);
      t_decode();
      t_refresh(4'hF, 1'b0);
      t_refresh(4'h0, 1'b1);
      t_tick();
      summarize();
   end
endmodule // tb
`default_nettype wire
